// file: bench/flc_unit_model.sv
// Execution and branch unit model that feeds flag updates and branch events.
// Assumes one clock, mclk; every request is a one-cycle pulse launched at a rising edge.
module flc_unit_model
  import flc_pkg::*;
(
  input  wire logic        mclk,
  output flc_op_type       exe_op,
  output logic             exe_valid,
  output logic             exe_oe,
  output logic             exe_ca_en,
  output logic      [63:0] exe_opa,
  output logic      [63:0] exe_opb,
  output logic             exe_cin,
  output logic      [6:0]  exe_shamt,
  output logic             exe_word,
  output logic             exe_too_wide,
  output logic             br_valid,
  output logic             br_link,
  output logic      [63:0] br_next_addr,
  output logic             br_dec_tally
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels at time zero, before any request.
  initial
  begin
    exe_op = FLC_OP_OTHER;
    exe_valid = 1'b0;
    exe_oe = 1'b0;
    exe_ca_en = 1'b0;
    exe_opa = 64'h0;
    exe_opb = 64'h0;
    exe_cin = 1'b0;
    exe_shamt = 7'h00;
    exe_word = 1'b0;
    exe_too_wide = 1'b0;
    br_valid = 1'b0;
    br_link = 1'b0;
    br_next_addr = 64'h0;
    br_dec_tally = 1'b0;
  end

  // One execution result; operands are inverted after release so stale values never match.
  task automatic exe(input flc_op_type op, input logic oe, ca, input logic [63:0] a, b,
                     input logic cin, input logic [6:0] sh, input logic w, tw);
    @(posedge mclk);
    exe_valid <= 1'b1;
    exe_op <= op;
    exe_oe <= oe;
    exe_ca_en <= ca;
    exe_opa <= a;
    exe_opb <= b;
    exe_cin <= cin;
    exe_shamt <= sh;
    exe_word <= w;
    exe_too_wide <= tw;
    @(posedge mclk);
    exe_valid <= 1'b0;
    exe_opa <= ~a;
    exe_opb <= ~b;
    #1;
  endtask

  // One branch event with optional link store and tally decrement.
  task automatic br(input logic lk, input logic [63:0] n, input logic dec);
    @(posedge mclk);
    br_valid <= 1'b1;
    br_link <= lk;
    br_next_addr <= n;
    br_dec_tally <= dec;
    @(posedge mclk);
    br_valid <= 1'b0;
    br_link <= 1'b0;
    br_dec_tally <= 1'b0;
    br_next_addr <= ~n;
    #1;
  endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the flag, return-target and loop-tally registers.
// Assumes the unit model drives all execution and branch inputs of the design.
module testbench
  import flc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk, rst_b, clk_en, spr_wr_en, spr_rd_en, spr_rd_valid, spr_rd_miss;
  logic [9:0]  spr_num;
  logic [63:0] spr_wr_data, spr_rd_data, exe_opa, exe_opb, br_next_addr;
  logic [63:0] return_target, tally_target;
  flc_op_type  exe_op;
  logic        exe_valid, exe_oe, exe_ca_en, exe_cin, exe_word, exe_too_wide;
  logic        br_valid, br_link, br_dec_tally, cond_valid;
  logic        sticky_flag, signed_wrap_flag, unsigned_out_flag;
  logic [6:0]  exe_shamt, byte_count;
  logic [3:0]  cond_field;
  int          miscompares = 0;
  int          comparisons = 0;
  localparam logic [63:0] MX = 64'h7fff_ffff_ffff_ffff;

  flc_regs dut_u (.mclk, .rst_b, .clk_en, .spr_num, .spr_wr_en, .spr_wr_data, .spr_rd_en,
    .spr_rd_data, .spr_rd_valid, .spr_rd_miss, .exe_valid, .exe_op, .exe_oe, .exe_ca_en,
    .exe_opa, .exe_opb, .exe_cin, .exe_shamt, .exe_word, .exe_too_wide, .cond_field,
    .cond_valid, .br_valid, .br_link, .br_next_addr, .br_dec_tally, .return_target,
    .tally_target, .byte_count, .sticky_flag, .signed_wrap_flag, .unsigned_out_flag);
  flc_unit_model um_u (.mclk, .exe_op, .exe_valid, .exe_oe, .exe_ca_en, .exe_opa, .exe_opb,
    .exe_cin, .exe_shamt, .exe_word, .exe_too_wide, .br_valid, .br_link, .br_next_addr,
    .br_dec_tally);

  // Free-running 40 MHz clock.
  always #12.5 mclk = ~mclk;

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Compares {sticky, overflow, carry} against the expected triple.
  task automatic fl(input logic [2:0] e);
    chk({61'h0, sticky_flag, signed_wrap_flag, unsigned_out_flag}, {61'h0, e});
  endtask

  task automatic wr(input logic [9:0] n, input logic [63:0] d);
    @(posedge mclk);
    spr_wr_en <= 1'b1;
    spr_num <= n;
    spr_wr_data <= d;
    @(posedge mclk);
    spr_wr_en <= 1'b0;
    spr_wr_data <= ~d;
    #1;
  endtask

  // Read latency is fixed at one cycle, so the answer is looked at right after that edge.
  task automatic rd(input logic [9:0] n, input logic [63:0] e, input logic m);
    @(posedge mclk);
    spr_rd_en <= 1'b1;
    spr_num <= n;
    @(posedge mclk);
    spr_rd_en <= 1'b0;
    #1;
    chk({63'h0, spr_rd_valid}, 64'h1);
    chk({63'h0, spr_rd_miss}, {63'h0, m});
    chk(spr_rd_data, e);
  endtask

  task automatic t_spr();
    rd(FLC_SPR_FLAGS, 64'h0, 1'b0);
    rd(10'h002, 64'h0, 1'b1);
    wr(FLC_SPR_FLAGS, '1);
    rd(FLC_SPR_FLAGS, 64'h0000_0000_e000_007f, 1'b0);
    chk({57'h0, byte_count}, 64'h7f);
    wr(FLC_SPR_RET, 64'h1234_5678_9abc_def3);
    rd(FLC_SPR_RET, 64'h1234_5678_9abc_def3, 1'b0);
    chk(return_target, 64'h1234_5678_9abc_def0);
    wr(FLC_SPR_TALLY, 64'h8765_4321_0000_0007);
    rd(FLC_SPR_TALLY, 64'h8765_4321_0000_0007, 1'b0);
    chk(tally_target, 64'h8765_4321_0000_0004);
    wr(FLC_SPR_FLAGS, 64'h0);
    fl(3'b000);
    $display("t_spr done");
  endtask

  task automatic t_add();
    um_u.exe(FLC_OP_ADD, 1'b1, 1'b0, MX, 64'h1, 1'b0, 7'h00, 1'b0, 1'b0);
    fl(3'b110);
    um_u.exe(FLC_OP_ADD, 1'b1, 1'b0, 64'h1, 64'h1, 1'b0, 7'h00, 1'b0, 1'b0);
    fl(3'b100);
    um_u.exe(FLC_OP_ADD, 1'b0, 1'b1, '1, 64'h0, 1'b1, 7'h00, 1'b0, 1'b0);
    fl(3'b101);
    um_u.exe(FLC_OP_OTHER, 1'b1, 1'b1, MX, MX, 1'b1, 7'h00, 1'b0, 1'b1);
    fl(3'b101);
    $display("t_add done");
  endtask

  task automatic t_muldiv();
    um_u.exe(FLC_OP_MULDIV, 1'b1, 1'b0, 64'h0, 64'h0, 1'b0, 7'h00, 1'b0, 1'b1);
    fl(3'b111);
    um_u.exe(FLC_OP_MULDIV, 1'b1, 1'b0, 64'h0, 64'h0, 1'b0, 7'h00, 1'b0, 1'b0);
    fl(3'b101);
    um_u.exe(FLC_OP_COPY, 1'b0, 1'b0, 64'h0, 64'h0, 1'b0, 7'h00, 1'b0, 1'b0);
    chk({63'h0, cond_valid}, 64'h1);
    chk({60'h0, cond_field}, 64'ha);
    fl(3'b000);
    um_u.exe(FLC_OP_ADD, 1'b1, 1'b0, MX, 64'h1, 1'b0, 7'h00, 1'b0, 1'b0);
    chk({63'h0, cond_valid}, 64'h0);
    wr(FLC_SPR_FLAGS, 64'h0000_0000_4000_0000);
    fl(3'b010);
    $display("t_muldiv done");
  endtask

  task automatic t_sra();
    um_u.exe(FLC_OP_SRA, 1'b0, 1'b0, 64'h8000_0000_0000_0001, 64'h0, 1'b0, 7'h01, 1'b0, 1'b0);
    fl(3'b011);
    um_u.exe(FLC_OP_SRA, 1'b0, 1'b0, 64'h8000_0000_0000_0002, 64'h0, 1'b0, 7'h01, 1'b0, 1'b0);
    fl(3'b010);
    um_u.exe(FLC_OP_SRA, 1'b0, 1'b0, 64'h0000_0000_0000_0003, 64'h0, 1'b0, 7'h01, 1'b0, 1'b0);
    fl(3'b010);
    um_u.exe(FLC_OP_SRA, 1'b0, 1'b0, 64'h0000_0000_8000_0001, 64'h0, 1'b0, 7'h01, 1'b1, 1'b0);
    fl(3'b011);
    // Word form must take its sign from bit 31, so this operand counts as positive.
    um_u.exe(FLC_OP_SRA, 1'b0, 1'b0, 64'h8000_0000_0000_0000, 64'h0, 1'b0, 7'h20, 1'b1, 1'b0);
    fl(3'b010);
    // A shift by the full width loses every bit, including the sign bit.
    um_u.exe(FLC_OP_SRA, 1'b0, 1'b0, 64'h8000_0000_0000_0000, 64'h0, 1'b0, 7'h40, 1'b0, 1'b0);
    fl(3'b011);
    $display("t_sra done");
  endtask

  // A frozen clock enable must hold the tally through a decrement request.
  task automatic t_br();
    wr(FLC_SPR_TALLY, 64'h0);
    um_u.br(1'b0, 64'h0, 1'b1);
    rd(FLC_SPR_TALLY, '1, 1'b0);
    @(posedge mclk);
    clk_en <= 1'b0;
    um_u.br(1'b0, 64'h0, 1'b1);
    @(posedge mclk);
    clk_en <= 1'b1;
    rd(FLC_SPR_TALLY, '1, 1'b0);
    um_u.br(1'b1, 64'h0000_0000_0000_1006, 1'b0);
    rd(FLC_SPR_RET, 64'h0000_0000_0000_1006, 1'b0);
    chk(return_target, 64'h0000_0000_0000_1004);
    $display("t_br done");
  endtask

  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog: a hung run counts as a mismatch.
  initial
  begin
    #2000000;
    miscompares++;
    end_sim();
  end

  // Main sequence: reset for four cycles, then each scenario in turn.
  initial
  begin
    mclk = 1'b0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    spr_wr_en = 1'b0;
    spr_rd_en = 1'b0;
    spr_num = 10'h000;
    spr_wr_data = 64'h0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    t_spr();
    t_add();
    t_muldiv();
    t_sra();
    t_br();
    end_sim();
  end
endmodule

// file: rtl/flc_regs.sv
// Flag register, return-target register and loop-tally register of a core.
// Assumes the execution and branch units drive their ports from logic on mclk,
// and that within one cycle a special-register write precedes any unit update.

module flc_regs
  import flc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic [9:0]  spr_num,
  input  wire logic        spr_wr_en,
  input  wire logic [63:0] spr_wr_data,
  input  wire logic        spr_rd_en,
  output logic      [63:0] spr_rd_data,
  output logic             spr_rd_valid,
  output logic             spr_rd_miss,
  input  wire logic        exe_valid,
  input  wire flc_op_type  exe_op,
  input  wire logic        exe_oe,
  input  wire logic        exe_ca_en,
  input  wire logic [63:0] exe_opa,
  input  wire logic [63:0] exe_opb,
  input  wire logic        exe_cin,
  input  wire logic [6:0]  exe_shamt,
  input  wire logic        exe_word,
  input  wire logic        exe_too_wide,
  output logic      [3:0]  cond_field,
  output logic             cond_valid,
  input  wire logic        br_valid,
  input  wire logic        br_link,
  input  wire logic [63:0] br_next_addr,
  input  wire logic        br_dec_tally,
  output logic      [63:0] return_target,
  output logic      [63:0] tally_target,
  output logic      [6:0]  byte_count,
  output logic             sticky_flag,
  output logic             signed_wrap_flag,
  output logic             unsigned_out_flag
);

  // Carry out of a shift-right-algebraic: negative operand and any one lost.
  function automatic logic sra_carry(input logic [63:0] v, input logic [6:0] sh,
                                     input logic word);
    logic [63:0] m;
    logic        neg;
    m   = '1;
    neg = word ? v[31] : v[63];
    if (word && sh < FLC_WORD_BITS)
      m = ~({64{1'b1}} << sh);
    else if (!word && sh < FLC_DWORD_BITS)
      m = ~({64{1'b1}} << sh);
    if (word)
      m = m & FLC_WORD_MASK;
    return neg & (|(v & m));
  endfunction

  logic        so_q, ov_q, ca_q;
  logic        so_d, ov_d, ca_d;
  logic        b_so, b_ov, b_ca;
  logic [6:0]  cnt_q, cnt_d;
  logic [63:0] ret_q, ret_d;
  logic [63:0] tally_q, tally_d;
  logic [64:0] add_sum;
  logic        add_ov, add_ca, sra_ca;
  logic        flags_wr, ret_wr, tally_wr, copy_op;
  logic [63:0] flags_view;

  // Write strobes decoded from the special register number; copy strobe decoded from the op class.
  assign flags_wr = spr_wr_en && spr_num == FLC_SPR_FLAGS;
  assign ret_wr   = spr_wr_en && spr_num == FLC_SPR_RET;
  assign tally_wr = spr_wr_en && spr_num == FLC_SPR_TALLY;
  assign copy_op  = exe_valid && exe_op == FLC_OP_COPY;

  // The full three-term sum is formed here, so a carry-in never hides a carry.
  assign add_sum = {1'b0, exe_opa} + {1'b0, exe_opb} + {64'h0, exe_cin};
  assign add_ca  = add_sum[64];
  assign add_ov  = add_sum[64] ^ (exe_opa[63] ^ exe_opb[63] ^ add_sum[63]);
  assign sra_ca  = sra_carry(exe_opa, exe_shamt, exe_word);

  // Flag next state: the register write first, the unit's update on top of it.
  always_comb
  begin
    b_so  = so_q;
    b_ov  = ov_q;
    b_ca  = ca_q;
    cnt_d = cnt_q;
    if (flags_wr)
    begin
      b_so  = spr_wr_data[FLC_SO_IDX];
      b_ov  = spr_wr_data[FLC_OV_IDX];
      b_ca  = spr_wr_data[FLC_CA_IDX];
      cnt_d = spr_wr_data[FLC_CNT_MSB:FLC_CNT_LSB];
    end
    so_d = b_so;
    ov_d = b_ov;
    ca_d = b_ca;
    if (exe_valid)
    begin
      case (exe_op)
        FLC_OP_ADD:
        begin
          if (exe_oe)
          begin
            ov_d = add_ov;
            so_d = b_so | add_ov;
          end
          if (exe_ca_en)
            ca_d = add_ca;
        end
        FLC_OP_MULDIV:
        begin
          if (exe_oe)
          begin
            ov_d = exe_too_wide;
            so_d = b_so | exe_too_wide;
          end
        end
        FLC_OP_SRA:   ca_d = sra_ca;
        FLC_OP_COPY:
        begin
          so_d = 1'b0;
          ov_d = 1'b0;
          ca_d = 1'b0;
        end
        default:      ;
      endcase
    end
  end

  // Flag storage; reserved positions have no flip-flops at all.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      so_q  <= 1'b0;
      ov_q  <= 1'b0;
      ca_q  <= 1'b0;
      cnt_q <= FLC_CNT_RST;
    end
    else if (clk_en)
    begin
      so_q  <= so_d;
      ov_q  <= ov_d;
      ca_q  <= ca_d;
      cnt_q <= cnt_d;
    end
  end

  // Copy of the flags toward the condition register, taken after any write.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cond_field <= 4'h0;
      cond_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      cond_valid <= copy_op;
      if (copy_op)
        cond_field <= {b_so, b_ov, b_ca, 1'b0};
    end
  end

  // Return target: a link update lands after a same-cycle register write.
  always_comb
  begin
    ret_d = ret_q;
    if (ret_wr)
      ret_d = spr_wr_data;
    if (br_valid && br_link)
      ret_d = br_next_addr;
  end

  // Loop tally: decrement of the freshly written value wraps zero to all ones.
  always_comb
  begin
    tally_d = tally_q;
    if (tally_wr)
      tally_d = spr_wr_data;
    if (br_valid && br_dec_tally)
      tally_d = tally_d - 64'h1;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ret_q   <= FLC_RET_RST;
      tally_q <= FLC_TALLY_RST;
    end
    else if (clk_en)
    begin
      ret_q   <= ret_d;
      tally_q <= tally_d;
    end
  end

  // Reads see zero in every reserved flag position.
  assign flags_view = {32'h0, so_q, ov_q, ca_q, 22'h0, cnt_q};

  // Read port answers one cycle later; unknown numbers return zero and a miss.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      spr_rd_data  <= 64'h0;
      spr_rd_valid <= 1'b0;
      spr_rd_miss  <= 1'b0;
    end
    else if (clk_en)
    begin
      spr_rd_valid <= spr_rd_en;
      spr_rd_miss  <= 1'b0;
      if (spr_rd_en)
      begin
        case (spr_num)
          FLC_SPR_FLAGS: spr_rd_data <= flags_view;
          FLC_SPR_RET:   spr_rd_data <= ret_q;
          FLC_SPR_TALLY: spr_rd_data <= tally_q;
          default:
          begin
            spr_rd_data <= 64'h0;
            spr_rd_miss <= 1'b1;
          end
        endcase
      end
    end
  end

  // Branch targets drop the low two bits; the stored copy keeps them.
  assign return_target     = ret_q & FLC_ADDR_MASK;
  assign tally_target      = tally_q & FLC_ADDR_MASK;
  assign byte_count        = cnt_q;
  assign sticky_flag       = so_q;
  assign signed_wrap_flag  = ov_q;
  assign unsigned_out_flag = ca_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_ov_event;
    clk_en && exe_valid && exe_oe &&
      ((exe_op == FLC_OP_ADD && add_ov) || (exe_op == FLC_OP_MULDIV && exe_too_wide));
  endsequence

  sequence s_quiet;
    clk_en && !flags_wr && !(exe_valid && exe_op != FLC_OP_SRA && exe_op != FLC_OP_OTHER);
  endsequence

  a_ov_sets_so: assert property (s_ov_event |=> so_q && ov_q)
    else $error("overflow event did not set both flags");
  a_sticky_holds: assert property (so_q && !(clk_en && (flags_wr || copy_op)) |=> so_q)
    else $error("sticky flag dropped without a write or copy");
  a_write_exact: assert property (clk_en && flags_wr && !exe_valid |=>
      so_q == $past(spr_wr_data[FLC_SO_IDX]) && ov_q == $past(spr_wr_data[FLC_OV_IDX]))
    else $error("flag write not stored as given");
  a_add_ov_calc: assert property (clk_en && exe_valid && exe_op == FLC_OP_ADD && exe_oe |=>
      ov_q == ($past(add_sum[64]) != ($past(exe_opa[63] ^ exe_opb[63] ^ add_sum[63]))))
    else $error("add overflow differs from msb carries");
  a_muldiv_ov: assert property (clk_en && exe_valid && exe_op == FLC_OP_MULDIV && exe_oe
      |=> ov_q == $past(exe_too_wide))
    else $error("multiply or divide overflow wrong");
  a_quiet_keep: assert property (s_quiet ##0 (exe_op != FLC_OP_SRA || !exe_valid)
      |=> $stable(ov_q) && $stable(ca_q))
    else $error("flags changed on a quiet instruction");
  a_add_carry: assert property (clk_en && exe_valid && exe_op == FLC_OP_ADD && exe_ca_en
      |=> ca_q == $past(add_sum[64]))
    else $error("carrying add stored wrong carry");
  a_sra_neg_pos: assert property (clk_en && exe_valid && exe_op == FLC_OP_SRA &&
      !(exe_word ? exe_opa[31] : exe_opa[63]) |=> !ca_q)
    else $error("shift of positive operand set carry");
  a_reserved_zero: assert property ((flags_view & ~FLC_FLAGS_MASK) == 64'h0)
    else $error("reserved flag bit reads nonzero");
  a_link_store: assert property (clk_en && br_valid && br_link |=>
      ret_q == $past(br_next_addr))
    else $error("link update not stored");
  a_target_low: assert property (return_target[1:0] == 2'b00 &&
      return_target[63:2] == ret_q[63:2])
    else $error("return target low bits not cleared");
  a_tally_wrap: assert property (clk_en && br_valid && br_dec_tally && !tally_wr &&
      tally_q == 64'h0 |=> tally_q == 64'hffff_ffff_ffff_ffff)
    else $error("tally did not wrap to all ones");
  a_read_ret: assert property (clk_en && spr_rd_en && spr_num == FLC_SPR_RET |=>
      spr_rd_valid && !spr_rd_miss && spr_rd_data == $past(ret_q))
    else $error("return register read wrong");

endmodule

// file: shared/flc_pkg.sv
// Constants and types shared by the flag, return-target and loop-tally registers.
// Assumes a 64-bit core; vector index 63-k holds the architectural bit k.
package flc_pkg;

  localparam int FLC_XLEN = 64;

  // Special register numbers used by the move-to and move-from instructions.
  localparam logic [9:0] FLC_SPR_FLAGS = 10'h001;
  localparam logic [9:0] FLC_SPR_RET   = 10'h008;
  localparam logic [9:0] FLC_SPR_TALLY = 10'h009;

  // Flag field positions in vector order (architectural bits 32, 33, 34, 57..63).
  localparam int FLC_SO_IDX  = 31;
  localparam int FLC_OV_IDX  = 30;
  localparam int FLC_CA_IDX  = 29;
  localparam int FLC_CNT_MSB = 6;
  localparam int FLC_CNT_LSB = 0;

  // Bits of the flag register that exist; all others are reserved.
  localparam logic [63:0] FLC_FLAGS_MASK = 64'h0000_0000_e000_007f;

  // Reset values.
  localparam logic [6:0]  FLC_CNT_RST   = 7'h00;
  localparam logic [63:0] FLC_RET_RST   = 64'h0000_0000_0000_0000;
  localparam logic [63:0] FLC_TALLY_RST = 64'h0000_0000_0000_0000;

  // Branch addresses ignore the two low bits.
  localparam logic [63:0] FLC_ADDR_MASK = 64'hffff_ffff_ffff_fffc;

  // Shift amount limits for word and doubleword forms.
  localparam logic [6:0] FLC_WORD_BITS  = 7'h20;
  localparam logic [6:0] FLC_DWORD_BITS = 7'h40;
  localparam logic [63:0] FLC_WORD_MASK = 64'h0000_0000_ffff_ffff;

  // Class of the instruction reported by the execution unit.
  typedef enum logic [2:0]
  {
    FLC_OP_OTHER  = 3'b000,
    FLC_OP_ADD    = 3'b001,
    FLC_OP_MULDIV = 3'b010,
    FLC_OP_SRA    = 3'b011,
    FLC_OP_COPY   = 3'b100
  } flc_op_type;

endpackage
